/* verilog/clsp_loop_config.sv */
// Purpose: APB register bank configuring the closed-loop speed and power regulation.
// Assumes: APB slave with zero wait states; one 10 MHz clock; synchronous active-high reset.
// Notes: Every printed offset is kept as a register index; byte address is four times it.
// Notes on behaviour
// - Proportional gain is the 10-bit field at bits 29:20, worth the value over 10000.
// - Integral gain is the 12-bit field at bits 19:8, worth the value over 1000000.
// - Upper clamp code at bits 7:5 selects 100, 95, 90, 85, 80, 75, 70 or 65 percent.
// - Lower clamp code at bits 4:2 selects 0, 2.5, 5, 7.5, 10, 15, 20 or 25 percent.
// - Loop selection at bits 1:0 picks off, speed loop, power loop, or reserved.
// - Maximum speed is the 16-bit field at bits 30:15, in hertz as value over 16.
// - Bit 14 turns dead time compensation on when one and off when zero.
// - Maximum power is the 10-bit field at bits 13:4, in watts as value over 4.
// - Hysteresis code at bits 3:2 selects 5, 7.5, 10 or 12.5 percent.
// - Power mode at bits 1:0 picks off, closed-loop power, power limit, or reserved.
// - Both registers reset to zero, leaving every loop off and compensation off.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
`include "clsp_map.svh"
module clsp_loop_config
	import clsp_pkg::*;
(
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Regulator measurements, from logic on the same clock
	input wire logic [15:0] i_meas_speed,
	input wire logic [9:0] i_meas_power,
	// Decoded configuration to the drive
	output logic o_loop_active,
	output logic o_speed_loop,
	output logic o_power_loop,
	output logic o_dead_band_correction_enable,
	output logic o_pwr_closed_loop,
	output logic o_pwr_limit,
	output logic [15:0] o_max_speed,
	output logic [9:0] o_max_power,
	output logic [15:0] o_input_power_hysteresis,
	// Regulator result
	output logic [15:0] o_loop_out,
	output logic o_loop_saturated
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [31:0] speed_loop_config_ff;
	logic [31:0] power_regulation_config_ff;
	logic [15:0] setpoint_ff;
	logic [31:0] setpoint_merged;
	logic [31:0] rd_data;
	logic access;
	logic wr_en;
	logic addr_hit;
	logic [9:0] loop_prop_gain;
	logic [11:0] loop_integ_gain;
	logic [2:0] loop_upper_clamp;
	logic [2:0] loop_lower_clamp;
	clsp_loop_mode_t loop_mode;
	clsp_pwr_mode_t pwr_mode;
	logic [1:0] input_power_hysteresis;
	logic [15:0] kp_q16;
	logic [15:0] ki_q16;
	logic [15:0] lim_hi;
	logic [15:0] lim_lo;
	logic [15:0] feedback;
	logic signed [16:0] loop_error;
	logic reg_enable;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] strb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction : strb_merge

	// Upper clamp table as a fraction of 0xFFFF full scale.
	function automatic logic [15:0] upper_clamp(input logic [2:0] code);
		case (code)
			3'h0: upper_clamp = 16'hFFFF;
			3'h1: upper_clamp = 16'hF332;
			3'h2: upper_clamp = 16'hE665;
			3'h3: upper_clamp = 16'hD998;
			3'h4: upper_clamp = 16'hCCCC;
			3'h5: upper_clamp = 16'hBFFF;
			3'h6: upper_clamp = 16'hB332;
			default: upper_clamp = 16'hA665;
		endcase
	endfunction : upper_clamp

	// Lower clamp table as a fraction of 0xFFFF full scale.
	function automatic logic [15:0] lower_clamp(input logic [2:0] code);
		case (code)
			3'h0: lower_clamp = 16'h0000;
			3'h1: lower_clamp = 16'h0666;
			3'h2: lower_clamp = 16'h0CCC;
			3'h3: lower_clamp = 16'h1333;
			3'h4: lower_clamp = 16'h1999;
			3'h5: lower_clamp = 16'h2666;
			3'h6: lower_clamp = 16'h3333;
			default: lower_clamp = 16'h3FFF;
		endcase
	endfunction : lower_clamp

	// Hysteresis band as a fraction of 0xFFFF full scale.
	function automatic logic [15:0] hyst_band(input logic [1:0] code);
		case (code)
			2'h0: hyst_band = 16'h0CCC;
			2'h1: hyst_band = 16'h1333;
			2'h2: hyst_band = 16'h1999;
			default: hyst_band = 16'h1FFF;
		endcase
	endfunction : hyst_band

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	// Zero wait states: the access phase completes in its first cycle.
	assign access = i_psel && i_penable;
	assign o_pready = 1'b1;
	assign addr_hit = (i_paddr == `CLSP_ADDR_SPEED_LOOP_CONFIG)
		|| (i_paddr == `CLSP_ADDR_POWER_REGULATION_CONFIG)
		|| (i_paddr == `CLSP_ADDR_LOOP_SETPOINT)
		|| (!i_pwrite && ((i_paddr == `CLSP_ADDR_LOOP_STATUS)
		|| (i_paddr == `CLSP_ADDR_LOOP_FEEDBACK)));
	assign o_pslverr = access && !addr_hit;
	assign wr_en = access && i_pwrite;

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			speed_loop_config_ff <= `CLSP_RST_SPEED_LOOP_CONFIG;
		end else if (wr_en && i_paddr == `CLSP_ADDR_SPEED_LOOP_CONFIG) begin
			speed_loop_config_ff <= strb_merge(speed_loop_config_ff, i_pwdata, i_pstrb);
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			power_regulation_config_ff <= `CLSP_RST_POWER_REGULATION_CONFIG;
		end else if (wr_en && i_paddr == `CLSP_ADDR_POWER_REGULATION_CONFIG) begin
			power_regulation_config_ff <= strb_merge(power_regulation_config_ff, i_pwdata,
				i_pstrb);
		end
	end

	assign setpoint_merged = strb_merge({16'h0000, setpoint_ff}, i_pwdata, i_pstrb);

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			setpoint_ff <= 16'h0000;
		end else if (wr_en && i_paddr == `CLSP_ADDR_LOOP_SETPOINT) begin
			setpoint_ff <= setpoint_merged[15:0];
		end
	end

	always_comb begin
		case (i_paddr)
			`CLSP_ADDR_SPEED_LOOP_CONFIG: rd_data = speed_loop_config_ff;
			`CLSP_ADDR_POWER_REGULATION_CONFIG: rd_data = power_regulation_config_ff;
			`CLSP_ADDR_LOOP_SETPOINT: rd_data = {16'h0000, setpoint_ff};
			`CLSP_ADDR_LOOP_STATUS: rd_data = {15'h0000, o_loop_saturated, o_loop_out};
			`CLSP_ADDR_LOOP_FEEDBACK: rd_data = {16'h0000, feedback};
			default: rd_data = 32'h00000000;
		endcase
	end

	// Read data is registered during setup so it stands in the access cycle.
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_prdata <= 32'h00000000;
		end else if (i_psel && !i_penable && !i_pwrite) begin
			o_prdata <= rd_data;
		end
	end

	// ----------------------------------------------------------------
	// Field extraction
	// ----------------------------------------------------------------
	assign loop_prop_gain = speed_loop_config_ff[`CLSP_KP_MSB:`CLSP_KP_LSB];
	assign loop_integ_gain = speed_loop_config_ff[`CLSP_KI_MSB:`CLSP_KI_LSB];
	assign loop_upper_clamp = speed_loop_config_ff[`CLSP_VMAX_MSB:`CLSP_VMAX_LSB];
	assign loop_lower_clamp = speed_loop_config_ff[`CLSP_VMIN_MSB:`CLSP_VMIN_LSB];
	assign loop_mode = clsp_loop_mode_t'(
		speed_loop_config_ff[`CLSP_LMODE_MSB:`CLSP_LMODE_LSB]);
	assign pwr_mode = clsp_pwr_mode_t'(
		power_regulation_config_ff[`CLSP_PMODE_MSB:`CLSP_PMODE_LSB]);
	assign input_power_hysteresis =
		power_regulation_config_ff[`CLSP_HYST_MSB:`CLSP_HYST_LSB];

	// Gains rescaled to 16-bit fractions; the integer divide is constant and folds away.
	assign kp_q16 = 16'((48'(loop_prop_gain) << 16) / `CLSP_KP_DIV);
	assign ki_q16 = 16'((48'(loop_integ_gain) << 32) / `CLSP_KI_DIV >> 16);
	assign lim_hi = upper_clamp(loop_upper_clamp);
	assign lim_lo = lower_clamp(loop_lower_clamp);

	// ----------------------------------------------------------------
	// Mode decode and outputs
	// ----------------------------------------------------------------
	always_comb begin
		o_speed_loop = 1'b0;
		o_power_loop = 1'b0;
		case (loop_mode)
			CLSP_LOOP_SPEED: o_speed_loop = 1'b1;
			CLSP_LOOP_POWER: o_power_loop = 1'b1;
			default: ;
		endcase
	end

	always_comb begin
		o_pwr_closed_loop = 1'b0;
		o_pwr_limit = 1'b0;
		case (pwr_mode)
			CLSP_PWR_CLOSED: o_pwr_closed_loop = 1'b1;
			CLSP_PWR_LIMIT: o_pwr_limit = 1'b1;
			default: ;
		endcase
	end

	assign o_loop_active = o_speed_loop || o_power_loop;
	assign o_dead_band_correction_enable = power_regulation_config_ff[`CLSP_DBC_BIT];
	assign o_max_speed = power_regulation_config_ff[`CLSP_MAXSPD_MSB:`CLSP_MAXSPD_LSB];
	assign o_max_power = power_regulation_config_ff[`CLSP_MAXPWR_MSB:`CLSP_MAXPWR_LSB];
	assign o_input_power_hysteresis = hyst_band(input_power_hysteresis);

	// ----------------------------------------------------------------
	// Regulator
	// ----------------------------------------------------------------
	// Power feedback is widened so both loops share one error path.
	assign feedback = o_power_loop ? {i_meas_power, 6'h00} : i_meas_speed;
	assign loop_error = $signed({1'b0, setpoint_ff}) - $signed({1'b0, feedback});
	assign reg_enable = o_loop_active;

	clsp_regulator u_regulator (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_enable(reg_enable),
		.i_kp(kp_q16),
		.i_ki(ki_q16),
		.i_lim_hi(lim_hi),
		.i_lim_lo(lim_lo),
		.i_error(loop_error),
		.o_out(o_loop_out),
		.o_saturated(o_loop_saturated)
	);

endmodule : clsp_loop_config

/* verilog/clsp_map.svh */
// Purpose: Register offsets, field positions and reset values of the loop configuration bank.
// Assumes: Byte addresses are four times the printed register index.
// Notes: Definitions only.
`ifndef CLSP_MAP_SVH
`define CLSP_MAP_SVH

// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define CLSP_IDX_SPEED_LOOP_CONFIG 8'h8E
`define CLSP_IDX_POWER_REGULATION_CONFIG 8'h90
`define CLSP_ADDR_SPEED_LOOP_CONFIG 12'h238
`define CLSP_ADDR_POWER_REGULATION_CONFIG 12'h240
`define CLSP_ADDR_LOOP_STATUS 12'h300
`define CLSP_ADDR_LOOP_SETPOINT 12'h304
`define CLSP_ADDR_LOOP_FEEDBACK 12'h308

// ----------------------------------------------------------------
// Speed loop configuration fields
// ----------------------------------------------------------------
`define CLSP_KP_MSB 29
`define CLSP_KP_LSB 20
`define CLSP_KI_MSB 19
`define CLSP_KI_LSB 8
`define CLSP_VMAX_MSB 7
`define CLSP_VMAX_LSB 5
`define CLSP_VMIN_MSB 4
`define CLSP_VMIN_LSB 2
`define CLSP_LMODE_MSB 1
`define CLSP_LMODE_LSB 0

// ----------------------------------------------------------------
// Power regulation configuration fields
// ----------------------------------------------------------------
`define CLSP_MAXSPD_MSB 30
`define CLSP_MAXSPD_LSB 15
`define CLSP_DBC_BIT 14
`define CLSP_MAXPWR_MSB 13
`define CLSP_MAXPWR_LSB 4
`define CLSP_HYST_MSB 3
`define CLSP_HYST_LSB 2
`define CLSP_PMODE_MSB 1
`define CLSP_PMODE_LSB 0

// ----------------------------------------------------------------
// Reset values and scaling
// ----------------------------------------------------------------
`define CLSP_RST_SPEED_LOOP_CONFIG 32'h00000000
`define CLSP_RST_POWER_REGULATION_CONFIG 32'h00000000
`define CLSP_KP_DIV 48'd10000
`define CLSP_KI_DIV 48'd1000000
`define CLSP_FULL_SCALE 16'hFFFF

`endif

/* verilog/clsp_pkg.sv */
// Purpose: Types shared by the loop configuration bank.
// Assumes: Nothing beyond the map header.
// Notes: Mode encodings follow the field codes.
package clsp_pkg;

	typedef enum logic [1:0] {
		CLSP_LOOP_OFF = 2'h0,
		CLSP_LOOP_SPEED = 2'h1,
		CLSP_LOOP_POWER = 2'h2,
		CLSP_LOOP_RSVD = 2'h3
	} clsp_loop_mode_t;

	typedef enum logic [1:0] {
		CLSP_PWR_OFF = 2'h0,
		CLSP_PWR_CLOSED = 2'h1,
		CLSP_PWR_LIMIT = 2'h2,
		CLSP_PWR_RSVD = 2'h3
	} clsp_pwr_mode_t;

endpackage : clsp_pkg

/* verilog/clsp_regulator.sv */
// Purpose: Proportional-integral regulator with selectable output clamps.
// Assumes: Gains already scaled into 16-bit fixed point by the caller.
// Notes: Output is a fraction of full scale, 0xFFFF meaning 100 percent.
`timescale 1ns/10ps
module clsp_regulator (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// Control
	input wire logic i_enable,
	input wire logic [15:0] i_kp,
	input wire logic [15:0] i_ki,
	input wire logic [15:0] i_lim_hi,
	input wire logic [15:0] i_lim_lo,
	// Error sample
	input wire logic signed [16:0] i_error,
	// Result
	output logic [15:0] o_out,
	output logic o_saturated
);

	logic signed [33:0] prop;
	logic signed [33:0] integ_step;
	logic signed [33:0] integ_ff;
	logic signed [33:0] nxt_integ;
	logic signed [34:0] sum;
	logic [15:0] nxt_out;
	logic nxt_sat;

	// ----------------------------------------------------------------
	// Terms
	// ----------------------------------------------------------------
	assign prop = i_error * $signed({1'b0, i_kp});
	assign integ_step = i_error * $signed({1'b0, i_ki});
	assign sum = 35'(prop) + 35'(integ_ff);

	// The integrator is held inside the clamps so it cannot wind up.
	always_comb begin
		nxt_integ = integ_ff + integ_step;
		if (nxt_integ > $signed({2'b00, i_lim_hi, 16'h0000})) begin
			nxt_integ = $signed({2'b00, i_lim_hi, 16'h0000});
		end else if (nxt_integ < $signed({2'b00, i_lim_lo, 16'h0000})) begin
			nxt_integ = $signed({2'b00, i_lim_lo, 16'h0000});
		end
	end

	always_comb begin
		nxt_sat = 1'b1;
		// The sum is signed, so a negative total must land on the lower clamp.
		if ($signed(sum[34:16]) > $signed({3'b000, i_lim_hi})) begin
			nxt_out = i_lim_hi;
		end else if ($signed(sum[34:16]) < $signed({3'b000, i_lim_lo})) begin
			nxt_out = i_lim_lo;
		end else begin
			nxt_out = sum[31:16];
			nxt_sat = 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst || !i_enable) begin
			integ_ff <= '0;
		end else begin
			integ_ff <= nxt_integ;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst || !i_enable) begin
			o_out <= 16'h0000;
			o_saturated <= 1'b0;
		end else begin
			o_out <= nxt_out;
			o_saturated <= nxt_sat;
		end
	end

endmodule : clsp_regulator

/* verif/clsp_loop_config_asserts.sv */
// Purpose: Port assertions for the loop configuration bank.
// Assumes: Zero-wait APB slave, full-word writes decode on the next edge.
// Notes: Sees only the top module ports.
`timescale 1ns/10ps
module clsp_loop_config_chk (
	// Clock, reset and APB
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	// Decoded outputs
	input wire logic o_loop_active,
	input wire logic o_speed_loop,
	input wire logic o_power_loop,
	input wire logic o_dead_band_correction_enable,
	input wire logic o_pwr_closed_loop,
	input wire logic o_pwr_limit,
	input wire logic [15:0] o_max_speed,
	input wire logic [9:0] o_max_power,
	input wire logic [15:0] o_input_power_hysteresis,
	input wire logic [15:0] o_loop_out
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	localparam logic [15:0] HYST [4] = '{16'h0CCC, 16'h1333, 16'h1999, 16'h1FFF};
	logic pwr_wr;
	assign pwr_wr = i_psel && i_penable && i_pwrite && i_paddr == 12'h240 && i_pstrb == 4'hF;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	chk_loop_decode: assert property (
		o_loop_active == (o_speed_loop || o_power_loop) && !(o_speed_loop && o_power_loop))
		else $error("loop mode outputs inconsistent");
	chk_pwr_decode: assert property (!(o_pwr_closed_loop && o_pwr_limit))
		else $error("both power modes active");
	chk_reset_zero: assert property ($past(i_rst) |-> o_max_speed == 16'h0000 &&
		o_max_power == 10'h000 && !o_loop_active && !o_dead_band_correction_enable &&
		!o_pwr_closed_loop && !o_pwr_limit) else $error("outputs not cleared by reset");
	chk_speed_write: assert property (pwr_wr |=> o_max_speed == $past(i_pwdata[30:15]))
		else $error("max speed does not follow write");
	chk_dbc_write: assert property (
		pwr_wr |=> o_dead_band_correction_enable == $past(i_pwdata[14]))
		else $error("compensation enable does not follow write");
	chk_power_write: assert property (pwr_wr |=> o_max_power == $past(i_pwdata[13:4]))
		else $error("max power does not follow write");
	chk_hyst_write: assert property (
		pwr_wr |=> o_input_power_hysteresis == HYST[$past(i_pwdata[3:2])])
		else $error("hysteresis decode wrong");
	chk_limit_write: assert property (
		pwr_wr |=> o_pwr_limit == ($past(i_pwdata[1:0]) == 2'h2))
		else $error("power limit decode wrong");
	chk_cfg_hold: assert property (
		!(i_psel && i_penable && i_pwrite) |=> $stable(o_max_speed) && $stable(o_max_power))
		else $error("limits changed without a write");
	chk_off_clears: assert property (!o_loop_active |=> o_loop_out == 16'h0000)
		else $error("regulator output not cleared while off");
	cov_pwr_wr: cover property (pwr_wr);
	cov_speed: cover property (o_speed_loop);
	cov_power: cover property (o_power_loop);
endmodule : clsp_loop_config_chk

/* verif/clsp_loop_config_tb.sv */
// Purpose: Self-checking bench for the loop configuration bank.
// Assumes: APB byte addresses 0x238 and 0x240, zero-gain regulator sits on its lower clamp.
// Notes: A two-word model tracks every write to 0x238 and 0x240, strobes included.
`timescale 1ns/10ps
module clsp_loop_config_tb;
	// ----------------------------------------------------------------
	// Signals and model
	// ----------------------------------------------------------------
	logic i_clk_sys = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
	logic [11:0] i_paddr = 12'h000;
	logic [31:0] i_pwdata = 32'h00000000, o_prdata, rd_q, m [2];
	logic [3:0] i_pstrb = 4'h0;
	logic [15:0] i_meas_speed = 16'h0000, o_max_speed, o_input_power_hysteresis, o_loop_out;
	logic [9:0] i_meas_power = 10'h000, o_max_power;
	logic o_pready, o_pslverr, o_loop_active, o_speed_loop, o_power_loop, o_pwr_closed_loop;
	logic o_dead_band_correction_enable, o_pwr_limit, o_loop_saturated, err_q;
	int fail_count = 0, compares = 0;
	localparam logic [11:0] ADDR [2] = '{12'h238, 12'h240};
	localparam logic [15:0] LO [8] = '{16'h0000, 16'h0666, 16'h0CCC, 16'h1333,
		16'h1999, 16'h2666, 16'h3333, 16'h3FFF};
	localparam logic [15:0] HI [8] = '{16'hFFFF, 16'hF332, 16'hE665, 16'hD998,
		16'hCCCC, 16'hBFFF, 16'hB332, 16'hA665};
	localparam logic [15:0] HY [4] = '{16'h0CCC, 16'h1333, 16'h1999, 16'h1FFF};
	clsp_loop_config uut (.i_clk_sys, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
		.i_pwdata, .i_pstrb, .o_prdata, .o_pready, .o_pslverr, .i_meas_speed, .i_meas_power,
		.o_loop_active, .o_speed_loop, .o_power_loop, .o_dead_band_correction_enable,
		.o_pwr_closed_loop, .o_pwr_limit, .o_max_speed, .o_max_power,
		.o_input_power_hysteresis, .o_loop_out, .o_loop_saturated);
	always #50 i_clk_sys = ~i_clk_sys;
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge i_clk_sys);
		i_psel <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= d;
		i_pstrb <= s;
		@(posedge i_clk_sys);
		i_penable <= 1'b1;
		do begin
			@(posedge i_clk_sys);
		end while (o_pready !== 1'b1);
		rd_q = o_prdata;
		err_q = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask : apb
	task automatic wreg(input int i, input logic [31:0] d, input logic [3:0] s);
		apb(1'b1, ADDR[i], d, s);
		for (int b = 0; b < 4; b++)
			if (s[b])
				m[i][8*b +: 8] = d[8*b +: 8];
	endtask : wreg
	task automatic check_all();
		@(posedge i_clk_sys);
		chk("max_speed", o_max_speed, m[1][30:15]);
		chk("dbc_en", o_dead_band_correction_enable, m[1][14]);
		chk("max_power", o_max_power, m[1][13:4]);
		chk("hysteresis", o_input_power_hysteresis, HY[m[1][3:2]]);
		chk("pwr_closed", o_pwr_closed_loop, m[1][1:0] == 2'h1);
		chk("pwr_limit", o_pwr_limit, m[1][1:0] == 2'h2);
		chk("speed_loop", o_speed_loop, m[0][1:0] == 2'h1);
		chk("power_loop", o_power_loop, m[0][1:0] == 2'h2);
		chk("loop_active", o_loop_active, m[0][1:0] inside {2'h1, 2'h2});
		for (int i = 0; i < 2; i++) begin
			apb(1'b0, ADDR[i], 32'h00000000, 4'h0);
			chk("readback", rd_q, m[i]);
		end
	endtask : check_all
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge i_clk_sys);
		fail_count++;
		stop_test();
	end
	initial begin
		void'($urandom(25756));
		m[0] = 32'h00000000;
		m[1] = 32'h00000000;
		repeat (10) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		check_all();
		$display("test reset done");
		for (int i = 0; i < 16; i++) begin
			i_meas_speed <= 16'($urandom);
			i_meas_power <= 10'($urandom);
			wreg(0, {$urandom} & 32'hFFFFFFFC | 32'(i % 3), 4'hF);
			wreg(1, {$urandom} & 32'hFFFFFFFC | 32'((i + 1) % 3), 4'hF);
			check_all();
		end
		$display("test fields done");
		foreach (HY[s]) begin
			wreg(s % 2, $urandom & 32'hFFFFFFFE, 4'h1 << s);
			wreg(1 - s % 2, $urandom & 32'hFFFFFFFE, 4'hC >> s);
			check_all();
		end
		$display("test strobes done");
		apb(1'b1, 12'h100, 32'hFFFFFFFF, 4'hF);
		chk("unmapped_wr_err", err_q, 1'b1);
		apb(1'b0, 12'h100, 32'h00000000, 4'h0);
		chk("unmapped_rd_err", err_q, 1'b1);
		chk("unmapped_rd", rd_q, 32'h00000000);
		check_all();
		$display("test unmapped done");
		for (int l = 0; l < 8; l++) begin
			wreg(0, 32'h00000000, 4'hF);
			wreg(1, 32'h00000000, 4'hF);
			apb(1'b1, 12'h304, $urandom & 32'h0000FFFF, 4'hF);
			wreg(0, 32'((7 - l) << 5 | l << 2 | 32'(l % 2 + 1)), 4'hF);
			repeat (6) @(posedge i_clk_sys);
			chk("loop_out", o_loop_out, LO[l]);
			chk("loop_sat", o_loop_saturated, 1'b0);
			check_all();
		end
		$display("test regulator done");
		for (int u = 0; u < 8; u++) begin
			i_meas_speed <= 16'h0000;
			apb(1'b1, 12'h304, 32'h0000FFFF, 4'hF);
			wreg(0, 32'h3FFFFF00 | 32'(u << 5) | 32'((7 - u) << 2) | 32'h1, 4'hF);
			repeat (300) @(posedge i_clk_sys);
			chk("clamp_hi", o_loop_out, HI[u]);
			chk("sat_hi", o_loop_saturated, 1'b1);
			apb(1'b0, 12'h300, 32'h00000000, 4'h0);
			chk("status", rd_q, {15'h0000, 1'b1, HI[u]});
			i_meas_speed <= 16'hFFFF;
			apb(1'b1, 12'h304, 32'h00000000, 4'hF);
			repeat (300) @(posedge i_clk_sys);
			chk("clamp_lo", o_loop_out, LO[7 - u]);
			chk("sat_lo", o_loop_saturated, 1'b1);
			apb(1'b0, 12'h308, 32'h00000000, 4'h0);
			chk("feedback", rd_q, 32'h0000FFFF);
			apb(1'b1, 12'h300, 32'h00000000, 4'hF);
			chk("ro_write_err", err_q, 1'b1);
			check_all();
		end
		$display("test clamps done");
		stop_test();
	end
endmodule : clsp_loop_config_tb
bind clsp_loop_config clsp_loop_config_chk u_chk (.i_clk_sys, .i_rst, .i_psel, .i_penable,
	.i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_loop_active, .o_speed_loop, .o_power_loop,
	.o_dead_band_correction_enable, .o_pwr_closed_loop, .o_pwr_limit, .o_max_speed,
	.o_max_power, .o_input_power_hysteresis, .o_loop_out);
